//--- design/uart_regs_pkg.sv
// constants for the modem change flags, scratch, divisor and mirror block
// Summary of operation
// [R1] dsr_n level change sets modem status bit 1
// [R2] cts_n level change sets modem status bit 0
// [R3] ri_n level change sets its change flag
// [R4] eight-bit scratch register, read-write, resets zero
// [R5] low divisor byte, present with infrared option
// [R6] high divisor byte, same option, resets zero
// [R7] receive buffer mirrored over sixteen words
// [R8] mirror built by option, only when latch bit 0
// [R9] mirror read pops oldest received character
// [R10] upper 24 bits read zero, writes ignored
package uart_regs_pkg;
   localparam int ADDR_W = 8;
   localparam logic [7:0] MODEM_STATUS_OFS = 8'h18;
   localparam logic [7:0] SCRATCH_OFS = 8'h1c;
   localparam logic [7:0] LP_DIV_LOW_OFS = 8'h20;
   localparam logic [7:0] LP_DIV_HIGH_OFS = 8'h24;
   localparam logic [7:0] MIRROR_FIRST_OFS = 8'h30;
   localparam logic [7:0] MIRROR_LAST_OFS = 8'h6c;
   localparam logic [7:0] IRQ_STATUS_OFS = 8'h90;
   localparam logic [7:0] IRQ_MASK_OFS = 8'h94;
   localparam int CTS_CHG_BIT = 0;
   localparam int DSR_CHG_BIT = 1;
   localparam int RI_CHG_BIT = 2;
   localparam int RI_LEVEL_BIT = 6;
   localparam int DSR_LEVEL_BIT = 5;
   localparam int CTS_LEVEL_BIT = 4;
   localparam logic [7:0] BYTE_RESET = 8'h00;
   localparam logic [2:0] SYNC_RESET = 3'h7;
endpackage

//--- design/modem_line_sync.sv
// two-stage synchronisers with edge detection for the modem lines
`timescale 1ns/10ps
`default_nettype none
module modem_line_sync #(
   parameter int WIDTH = 3
) (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic [WIDTH-1:0] lineIn,
   output logic [WIDTH-1:0] lineSync,
   output logic [WIDTH-1:0] lineChange
);
   logic [WIDTH-1:0] stage1_q, stage1_d;
   logic [WIDTH-1:0] stage2_q, stage2_d;
   logic [WIDTH-1:0] stage3_q, stage3_d;

   // lines idle high; first stage feeds only the second
   always_comb begin
      stage1_d = lineIn;
      stage2_d = stage1_q;
      stage3_d = stage2_q;
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         stage1_q <= '1;
         stage2_q <= '1;
         stage3_q <= '1;
      end else begin
         stage1_q <= stage1_d;
         stage2_q <= stage2_d;
         stage3_q <= stage3_d;
      end
   end

   assign lineSync = stage2_q;
   // either direction counts as a change
   assign lineChange = stage2_q ^ stage3_q;
endmodule
`default_nettype wire

//--- design/uart_modem_delta_scratch_regs.sv
// modem change flags, scratch, low-power divisor and receive mirror
`timescale 1ns/10ps
`default_nettype none
module uart_modem_delta_scratch_regs
   import uart_regs_pkg::*;
#(
   parameter bit LOWPOWER_IR_RX = 1'b1,
   parameter bit MIRROR_BUILT = 1'b1
) (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic [ADDR_W-1:0] regAddr,
   input wire logic [31:0] regWdata,
   input wire logic regWrite,
   input wire logic regRead,
   output logic [31:0] regRdata,
   input wire logic ctsLine_n,
   input wire logic dsrLine_n,
   input wire logic riLine_n,
   input wire logic divisorLatchAccess,
   input wire logic [7:0] rxHoldingData,
   input wire logic rxDataReady,
   output logic rxPop,
   output logic [15:0] lowpowerDivisor,
   output logic irq
);
   // -------------------------------------------------------------
   // address decode
   // -------------------------------------------------------------
   function automatic logic isMirror(input logic [ADDR_W-1:0] a);
      isMirror = (a >= MIRROR_FIRST_OFS) && (a <= MIRROR_LAST_OFS)
                 && (a[1:0] == 2'b00);
   endfunction

   logic [2:0] lineSync, lineChange;
   logic [2:0] chg_q, chg_d;
   logic [2:0] irqStat_q, irqStat_d;
   logic [2:0] irqMask_q, irqMask_d;
   logic [7:0] scratch_q, scratch_d;
   logic [7:0] divLow_q, divLow_d;
   logic [7:0] divHigh_q, divHigh_d;
   logic [31:0] rdata_q, rdata_d;
   logic statusRead, mirrorRead;

   // -------------------------------------------------------------
   // modem line synchronisers
   // -------------------------------------------------------------
   modem_line_sync #(
      .WIDTH(3)
   ) u_sync (
      .clk(clk),
      .sys_rst(sys_rst),
      .lineIn({riLine_n, dsrLine_n, ctsLine_n}),
      .lineSync(lineSync),
      .lineChange(lineChange)
   );

   assign statusRead = regRead && (regAddr == MODEM_STATUS_OFS);
   // [R8] mirror gated by option
   // access refused while the divisor latch is selected
   assign mirrorRead = MIRROR_BUILT && regRead && isMirror(regAddr)
                       && !divisorLatchAccess;

   // -------------------------------------------------------------
   // change flags and interrupt status
   // -------------------------------------------------------------
   // a change in the read cycle is returned by that read, so the
   // read consumes it; keeping it would report one edge twice
   always_comb begin
      chg_d = chg_q;
      irqStat_d = (regRead && regAddr == IRQ_STATUS_OFS) ? 3'b000
                  : irqStat_q;
      // [R2] cts change flag
      chg_d[CTS_CHG_BIT] = chg_d[CTS_CHG_BIT] | lineChange[0];
      // [R1] dsr change flag
      chg_d[DSR_CHG_BIT] = chg_d[DSR_CHG_BIT] | lineChange[1];
      // [R3] ri change flag
      chg_d[RI_CHG_BIT] = chg_d[RI_CHG_BIT] | lineChange[2];
      if (statusRead) begin
         chg_d = 3'b000;
      end
      irqStat_d = irqStat_d | lineChange;
      irqMask_d = irqMask_q;
      if (regWrite && regAddr == IRQ_MASK_OFS) begin
         irqMask_d = regWdata[2:0];
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         chg_q <= 3'b000;
         irqStat_q <= 3'b000;
         irqMask_q <= 3'b000;
      end else begin
         chg_q <= chg_d;
         irqStat_q <= irqStat_d;
         irqMask_q <= irqMask_d;
      end
   end

   assign irq = |(irqStat_q & irqMask_q);

   // -------------------------------------------------------------
   // scratch and low-power divisor
   // -------------------------------------------------------------
   // [R10] only the low byte is stored
   always_comb begin
      scratch_d = scratch_q;
      divLow_d = divLow_q;
      divHigh_d = divHigh_q;
      // [R4] scratch write
      if (regWrite && regAddr == SCRATCH_OFS) begin
         scratch_d = regWdata[7:0];
      end
      // [R5] low divisor byte write
      if (LOWPOWER_IR_RX && regWrite && regAddr == LP_DIV_LOW_OFS) begin
         divLow_d = regWdata[7:0];
      end
      // [R6] high divisor byte write
      if (LOWPOWER_IR_RX && regWrite && regAddr == LP_DIV_HIGH_OFS) begin
         divHigh_d = regWdata[7:0];
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         scratch_q <= BYTE_RESET;
         divLow_q <= BYTE_RESET;
         divHigh_q <= BYTE_RESET;
      end else begin
         scratch_q <= scratch_d;
         divLow_q <= divLow_d;
         divHigh_q <= divHigh_d;
      end
   end

   assign lowpowerDivisor = {divHigh_q, divLow_q};

   // -------------------------------------------------------------
   // read data, one cycle after the strobe
   // -------------------------------------------------------------
   always_comb begin
      rdata_d = 32'h0000_0000;
      if (regRead) begin
         if (regAddr == MODEM_STATUS_OFS) begin
            rdata_d[CTS_CHG_BIT] = chg_q[CTS_CHG_BIT] | lineChange[0];
            rdata_d[DSR_CHG_BIT] = chg_q[DSR_CHG_BIT] | lineChange[1];
            rdata_d[RI_CHG_BIT] = chg_q[RI_CHG_BIT] | lineChange[2];
            rdata_d[CTS_LEVEL_BIT] = ~lineSync[0];
            rdata_d[DSR_LEVEL_BIT] = ~lineSync[1];
            rdata_d[RI_LEVEL_BIT] = ~lineSync[2];
         end else if (regAddr == SCRATCH_OFS) begin
            rdata_d[7:0] = scratch_q;
         end else if (LOWPOWER_IR_RX && regAddr == LP_DIV_LOW_OFS) begin
            rdata_d[7:0] = divLow_q;
         end else if (LOWPOWER_IR_RX && regAddr == LP_DIV_HIGH_OFS) begin
            rdata_d[7:0] = divHigh_q;
         end else if (regAddr == IRQ_STATUS_OFS) begin
            rdata_d[2:0] = irqStat_q;
         end else if (regAddr == IRQ_MASK_OFS) begin
            rdata_d[2:0] = irqMask_q;
         end else if (mirrorRead) begin
            // [R7] any of sixteen words
            rdata_d[7:0] = rxHoldingData;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         rdata_q <= 32'h0000_0000;
      end else begin
         rdata_q <= rdata_d;
      end
   end

   assign regRdata = rdata_q;
   // [R9] mirror read pops receive path
   // no pop when nothing is waiting, so an empty read is harmless
   assign rxPop = mirrorRead && rxDataReady;
endmodule
`default_nettype wire

//--- tb/uart_regs_checker.sv
// port assertions for the modem flag, divisor and mirror block
`timescale 1ns/10ps
`default_nettype none
module uart_regs_checker
   import uart_regs_pkg::*;
(
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic [ADDR_W-1:0] regAddr,
   input wire logic [31:0] regWdata,
   input wire logic regWrite,
   input wire logic regRead,
   input wire logic [31:0] regRdata,
   input wire logic dsrLine_n,
   input wire logic divisorLatchAccess,
   input wire logic [7:0] rxHoldingData,
   input wire logic rxDataReady,
   input wire logic rxPop,
   input wire logic [15:0] lowpowerDivisor,
   input wire logic irq
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (sys_rst);
   logic hit;
   // word aligned hit inside the mirror window
   assign hit = regAddr >= MIRROR_FIRST_OFS &&
      regAddr <= MIRROR_LAST_OFS && regAddr[1:0] == 2'h0;
   a_rdata_idle: assert property (
      !$past(regRead) |-> regRdata == 32'h0) else $error("stray data");
   a_upper_zero: assert property (
      regRdata[31:8] == 24'h0) else $error("upper bits set");
   a_pop_cause: assert property (
      rxPop |-> regRead && hit && rxDataReady && !divisorLatchAccess)
      else $error("stray pop");
   a_pop_taken: assert property (
      regRead && hit && rxDataReady && !divisorLatchAccess |-> rxPop)
      else $error("missing pop");
   a_mirror_data: assert property (
      $past(rxPop) |-> regRdata == {24'h0, $past(rxHoldingData)})
      else $error("mirror data");
   a_div_low: assert property (
      regWrite && regAddr == LP_DIV_LOW_OFS |=>
      lowpowerDivisor[7:0] == 8'($past(regWdata))) else $error("div low");
   a_div_high: assert property (
      regWrite && regAddr == LP_DIV_HIGH_OFS |=>
      lowpowerDivisor[15:8] == 8'($past(regWdata))) else $error("div high");
   a_dsr_flag: assert property (
      $changed(dsrLine_n) ##1 !regRead [*2] ##1 regRead &&
      regAddr == MODEM_STATUS_OFS |=> regRdata[DSR_CHG_BIT])
      else $error("dsr flag");
   c_pop: cover property (rxPop);
   c_irq: cover property (irq ##1 !irq);
   c_high: cover property (regWrite && regAddr == LP_DIV_HIGH_OFS);
endmodule
bind uart_modem_delta_scratch_regs uart_regs_checker uart_regs_checker_i (
   .clk(clk), .sys_rst(sys_rst), .regAddr(regAddr), .regWdata(regWdata),
   .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata),
   .dsrLine_n(dsrLine_n), .divisorLatchAccess(divisorLatchAccess),
   .rxHoldingData(rxHoldingData), .rxDataReady(rxDataReady),
   .rxPop(rxPop), .lowpowerDivisor(lowpowerDivisor), .irq(irq));
`default_nettype wire

//--- tb/rx_char_source.sv
// receive path model: three characters per fill
`timescale 1ns/10ps
`default_nettype none
module rx_char_source (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic fill,
   input wire logic rxPop,
   output logic [7:0] rxHoldingData,
   output logic rxDataReady
);
   logic [7:0] head_q, head_d;
   logic [3:0] cnt_q, cnt_d;
   always_comb begin
      head_d = head_q + {7'h0, rxPop & rxDataReady};
      cnt_d = fill ? 4'h3 : cnt_q - {3'h0, rxPop & rxDataReady};
   end
   always_ff @(posedge clk) begin
      head_q <= sys_rst ? 8'ha0 : head_d;
      cnt_q <= sys_rst ? 4'h0 : cnt_d;
   end
   assign rxDataReady = cnt_q != 4'h0;
   // empty shows inverted data so stale reads are caught
   assign rxHoldingData = rxDataReady ? head_q : ~head_q;
endmodule
`default_nettype wire

//--- tb/uart_modem_delta_scratch_regs_tb_top.sv
// bench for the modem flag, scratch, divisor and mirror block
`timescale 1ns/10ps
`default_nettype none
module uart_modem_delta_scratch_regs_tb_top import uart_regs_pkg::*;;
   logic clk = 0, sys_rst = 1, we = 0, re = 0, dla = 0, fill = 0;
   logic pop, rdy, irq;
   logic [7:0] addr = 8'h0, rxData;
   logic [31:0] wdata = 32'h0, rdata;
   logic [2:0] lines = 3'h7;
   logic [15:0] div;
   int n_fail = 0, n_compared = 0, cycles = 0;
   uart_modem_delta_scratch_regs uart_modem_delta_scratch_regs_i (
      .clk(clk), .sys_rst(sys_rst), .regAddr(addr), .regWdata(wdata),
      .regWrite(we), .regRead(re), .regRdata(rdata), .ctsLine_n(lines[0]),
      .dsrLine_n(lines[1]), .riLine_n(lines[2]), .divisorLatchAccess(dla),
      .rxHoldingData(rxData), .rxDataReady(rdy), .rxPop(pop),
      .lowpowerDivisor(div), .irq(irq));
   rx_char_source rx_char_source_i (.clk(clk), .sys_rst(sys_rst),
      .fill(fill), .rxPop(pop), .rxHoldingData(rxData), .rxDataReady(rdy));
   initial forever #12.5 clk = ~clk;
   // hang guard, runs need well under this
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 3000) begin
         n_fail++;
         final_report();
      end
   end
   task automatic final_report();
      if (n_fail == 0 && n_compared > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         n_fail++;
         $display("unexpected at %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic busWr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      we <= 1'b1;
      addr <= a;
      wdata <= d;
      @(posedge clk);
      we <= 1'b0;
   endtask
   // data stands only in the cycle after the strobe
   task automatic busRd(input logic [7:0] a, input logic [31:0] exp);
      @(posedge clk);
      re <= 1'b1;
      addr <= a;
      @(posedge clk);
      re <= 1'b0;
      #1 chk(rdata, exp);
   endtask
   task automatic regsTest();
      chk({16'h0, div}, 32'h0);
      busRd(SCRATCH_OFS, 32'h0);
      busRd(LP_DIV_HIGH_OFS, 32'h0);
      busWr(SCRATCH_OFS, 32'hffff_ff5a);
      busWr(LP_DIV_LOW_OFS, 32'h0000_0134);
      busWr(LP_DIV_HIGH_OFS, 32'h0000_ab12);
      busWr(8'h28, 32'h0000_00ff);
      busRd(SCRATCH_OFS, 32'h5a);
      busRd(LP_DIV_LOW_OFS, 32'h34);
      chk({16'h0, div}, 32'h1234);
      busRd(8'h28, 32'h0);
   endtask
   task automatic modemTest();
      logic [31:0] lvl;
      busWr(IRQ_MASK_OFS, 32'h7);
      for (int i = 0; i < 3; i++) begin
         @(posedge clk);
         lines[i] <= 1'b0;
         repeat (2) @(posedge clk);
         lvl = {25'h0, ~lines, 4'h0};
         busRd(MODEM_STATUS_OFS, lvl | 32'h1 << i);
         chk({31'h0, irq}, 32'h1);
         busRd(MODEM_STATUS_OFS, lvl);
         busRd(IRQ_STATUS_OFS, 32'h1 << i);
         @(posedge clk);
         #1 chk({31'h0, irq}, 32'h0);
      end
      busWr(IRQ_MASK_OFS, 32'h0);
      @(posedge clk);
      lines[0] <= 1'b1;
      repeat (4) @(posedge clk);
      #1 chk({31'h0, irq}, 32'h0);
      busRd(IRQ_STATUS_OFS, 32'h1);
   endtask
   task automatic mirrorTest();
      @(posedge clk);
      fill <= 1'b1;
      @(posedge clk);
      fill <= 1'b0;
      busRd(MIRROR_FIRST_OFS, 32'ha0);
      busRd(MIRROR_LAST_OFS, 32'ha1);
      @(posedge clk);
      dla <= 1'b1;
      busRd(MIRROR_FIRST_OFS, 32'h0);
      @(posedge clk);
      dla <= 1'b0;
      busRd(8'h34, 32'ha2);
   endtask
   initial begin
      repeat (6) @(posedge clk);
      sys_rst <= 1'b0;
      regsTest();
      modemTest();
      mirrorTest();
      final_report();
   end
endmodule
`default_nettype wire
